// ===== harm_regs_pkg.sv
package harm_regs_pkg;

  // ----------------------------------------
  // Address map
  // ----------------------------------------
  localparam logic [15:0] ADDR_HARM_Y_VOLT_DISTORTION    = 16'he896;
  localparam logic [15:0] ADDR_HARM_Y_CURR_DISTORTION    = 16'he897;
  localparam logic [15:0] ADDR_HARM_Z_VOLT_RMS           = 16'he898;
  localparam logic [15:0] ADDR_HARM_Z_CURR_RMS           = 16'he899;
  localparam logic [15:0] ADDR_HARM_Z_ACTIVE_POWER       = 16'he89a;
  localparam logic [15:0] ADDR_HARM_Z_REACTIVE_POWER     = 16'he89b;
  localparam logic [15:0] ADDR_HARM_Z_APPARENT_POWER     = 16'he89c;
  localparam logic [15:0] ADDR_HARM_Z_POWER_FACTOR       = 16'he89d;
  localparam logic [15:0] ADDR_HARM_Z_VOLT_DISTORTION    = 16'he89e;
  localparam logic [15:0] ADDR_HARM_Z_CURR_DISTORTION    = 16'he89f;
  localparam logic [15:0] ADDR_HARMONIC_CALC_CONFIG      = 16'he900;
  localparam logic [15:0] ADDR_PHASE_A_POWER_FACTOR      = 16'he902;
  localparam logic [15:0] ADDR_PHASE_B_POWER_FACTOR      = 16'he903;
  localparam logic [15:0] ADDR_PHASE_C_POWER_FACTOR      = 16'he904;
  localparam logic [15:0] ADDR_PHASE_A_LINE_PERIOD       = 16'he905;
  localparam logic [15:0] ADDR_PHASE_B_LINE_PERIOD       = 16'he906;
  localparam logic [15:0] ADDR_PHASE_C_LINE_PERIOD       = 16'he907;
  localparam logic [15:0] ADDR_ACTIVE_NOLOAD_THRESHOLD   = 16'he908;
  localparam logic [15:0] ADDR_REACTIVE_NOLOAD_THRESHOLD = 16'he909;
  localparam logic [15:0] ADDR_APPARENT_NOLOAD_THRESHOLD = 16'he90a;
  localparam logic [15:0] ADDR_LAST_ACCESS_ADDRESS       = 16'he9fe;
  localparam logic [15:0] ADDR_LAST_WORD_DATA            = 16'he9ff;
  localparam logic [15:0] ADDR_GENERAL_CONFIG_THREE      = 16'hea00;
  localparam logic [15:0] ADDR_LAST_OPERATION_TYPE       = 16'hea01;
  localparam logic [15:0] ADDR_ACTIVE_PATH_THRESHOLD     = 16'hea02;
  localparam logic [15:0] ADDR_REACTIVE_PATH_THRESHOLD   = 16'hea03;
  localparam logic [15:0] ADDR_APPARENT_PATH_THRESHOLD   = 16'hea04;
  localparam logic [15:0] ADDR_FIRST_HARMONIC_SELECTOR   = 16'hea08;
  localparam logic [15:0] ADDR_SECOND_HARMONIC_SELECTOR  = 16'hea09;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [15:0] RST_HARMONIC_CALC_CONFIG = 16'h0008;
  localparam logic [15:0] RST_NOLOAD_THRESHOLD     = 16'h0000;
  localparam logic [7:0]  RST_GENERAL_CONFIG_THREE = 8'h01;
  localparam logic [7:0]  RST_PATH_THRESHOLD       = 8'h03;
  localparam logic [7:0]  RST_FIRST_HARMONIC_SEL   = 8'h03;
  localparam logic [7:0]  RST_SECOND_HARMONIC_SEL  = 8'h05;

  // ----------------------------------------
  // Operation type codes and forbidden value
  // ----------------------------------------
  localparam logic [7:0]  OP_CODE_READ         = 8'h35;
  localparam logic [7:0]  OP_CODE_WRITE        = 8'hca;
  localparam logic [7:0]  OP_CODE_NONE         = 8'h00;
  localparam logic [15:0] NOLOAD_FORBIDDEN_VAL = 16'hffff;

  // Results of the third harmonic set, 24-bit signed
  typedef struct packed {
    logic [23:0] volt_rms;
    logic [23:0] curr_rms;
    logic [23:0] active_power;
    logic [23:0] reactive_power;
    logic [23:0] apparent_power;
    logic [23:0] power_factor;
    logic [23:0] volt_distortion;
    logic [23:0] curr_distortion;
  } harm_z_results_t;

  // Per-phase results and the second set's distortion
  typedef struct packed {
    logic [23:0] y_volt_distortion;
    logic [23:0] y_curr_distortion;
    logic [15:0] pf_a;
    logic [15:0] pf_b;
    logic [15:0] pf_c;
    logic [15:0] period_a;
    logic [15:0] period_b;
    logic [15:0] period_c;
  } phase_results_t;

  // Configuration handed to the signal path
  typedef struct packed {
    logic [15:0] harmonic_calc_config;
    logic [15:0] active_noload;
    logic [15:0] reactive_noload;
    logic [15:0] apparent_noload;
    logic [7:0]  general_config_three;
    logic [7:0]  active_path_thr;
    logic [7:0]  reactive_path_thr;
    logic [7:0]  apparent_path_thr;
    logic [7:0]  first_harmonic_sel;
    logic [7:0]  second_harmonic_sel;
  } harm_config_t;

endpackage

// ===== harm_result_regs.sv
// What this block does
// - Unmapped addresses in this map always read as zero.
// - Apparent no-load threshold is 16-bit read/write, resets to zero.
// - Every successful read or write records its address in a read-only register.
// - Every successful 16-bit access copies its data word into a capture register.
// - An 8-bit read-only register tells whether last operation was read or write.
// - Two 8-bit harmonic index selectors, reset to three and five.
// - Third harmonic rms and power results are signed 24-bit, carried in 32 bits.
// - Second and third harmonic distortion results are signed 24-bit read-only.
// - Each phase has a signed 16-bit read-only power factor.
// - Each phase has an unsigned 16-bit read-only line period.
// - Three 8-bit path thresholds, read/write, each reset to three.
// - Harmonic calculation configuration is 16-bit read/write, reset eight.
// - General 8-bit configuration register resets to one.
// - Signed 24-bit values are sign extended into the upper byte.
// - Signed results are two's complement, unsigned ones plain binary.
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none

module harm_result_regs
  import harm_regs_pkg::*;
(
  input  wire logic            sys_clk,
  input  wire logic            reset,
  input  wire logic [15:0]     reg_addr,
  input  wire logic [31:0]     reg_wdata,
  input  wire logic            reg_wr,
  input  wire logic            reg_rd,
  output var  logic [31:0]     reg_rdata,
  input  wire harm_z_results_t harm_z_in,
  input  wire phase_results_t  phase_in,
  output var  harm_config_t    config_out
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------

  // Two's complement 24-bit value widened to a 32-bit word
  function automatic logic [31:0] sext24(input logic [23:0] v);
    sext24 = {{8{v[23]}}, v};
  endfunction

  // Width class of a mapped register: 2 = 32-bit word, 1 = 16-bit, 0 = 8-bit
  function automatic logic [1:0] width_class(input logic [15:0] a);
    if (a >= ADDR_HARM_Y_VOLT_DISTORTION && a <= ADDR_HARM_Z_CURR_DISTORTION) begin
      width_class = 2'h2;
    end else if (a >= ADDR_HARMONIC_CALC_CONFIG && a <= ADDR_LAST_WORD_DATA) begin
      width_class = 2'h1;
    end else begin
      width_class = 2'h0;
    end
  endfunction

  logic [15:0] hcfg_ff;
  logic [15:0] act_noload_ff;
  logic [15:0] react_noload_ff;
  logic [15:0] app_noload_ff;
  logic [7:0]  cfg3_ff;
  logic [7:0]  act_thr_ff;
  logic [7:0]  react_thr_ff;
  logic [7:0]  app_thr_ff;
  logic [7:0]  sel_first_ff;
  logic [7:0]  sel_second_ff;
  logic [15:0] last_addr_ff;
  logic [15:0] last_data_ff;
  logic [7:0]  last_operation_type_ff;
  logic [31:0] nxt_rdata;
  logic        hit;

  // ----------------------------------------
  // Read decode
  // ----------------------------------------

  // Unlisted addresses fall to zero; hit marks a mapped register
  always_comb begin
    nxt_rdata = 32'h0000_0000;
    hit       = 1'b1;
    case (reg_addr)
      ADDR_HARM_Y_VOLT_DISTORTION:    nxt_rdata = sext24(phase_in.y_volt_distortion);
      ADDR_HARM_Y_CURR_DISTORTION:    nxt_rdata = sext24(phase_in.y_curr_distortion);
      ADDR_HARM_Z_VOLT_RMS:           nxt_rdata = sext24(harm_z_in.volt_rms);
      ADDR_HARM_Z_CURR_RMS:           nxt_rdata = sext24(harm_z_in.curr_rms);
      ADDR_HARM_Z_ACTIVE_POWER:       nxt_rdata = sext24(harm_z_in.active_power);
      ADDR_HARM_Z_REACTIVE_POWER:     nxt_rdata = sext24(harm_z_in.reactive_power);
      ADDR_HARM_Z_APPARENT_POWER:     nxt_rdata = sext24(harm_z_in.apparent_power);
      ADDR_HARM_Z_POWER_FACTOR:       nxt_rdata = sext24(harm_z_in.power_factor);
      ADDR_HARM_Z_VOLT_DISTORTION:    nxt_rdata = sext24(harm_z_in.volt_distortion);
      ADDR_HARM_Z_CURR_DISTORTION:    nxt_rdata = sext24(harm_z_in.curr_distortion);
      ADDR_HARMONIC_CALC_CONFIG:      nxt_rdata = {16'h0000, hcfg_ff};
      // Power factor is signed but travels as a 16-bit word, upper half zero
      ADDR_PHASE_A_POWER_FACTOR:      nxt_rdata = {16'h0000, phase_in.pf_a};
      ADDR_PHASE_B_POWER_FACTOR:      nxt_rdata = {16'h0000, phase_in.pf_b};
      ADDR_PHASE_C_POWER_FACTOR:      nxt_rdata = {16'h0000, phase_in.pf_c};
      ADDR_PHASE_A_LINE_PERIOD:       nxt_rdata = {16'h0000, phase_in.period_a};
      ADDR_PHASE_B_LINE_PERIOD:       nxt_rdata = {16'h0000, phase_in.period_b};
      ADDR_PHASE_C_LINE_PERIOD:       nxt_rdata = {16'h0000, phase_in.period_c};
      ADDR_ACTIVE_NOLOAD_THRESHOLD:   nxt_rdata = {16'h0000, act_noload_ff};
      ADDR_REACTIVE_NOLOAD_THRESHOLD: nxt_rdata = {16'h0000, react_noload_ff};
      ADDR_APPARENT_NOLOAD_THRESHOLD: nxt_rdata = {16'h0000, app_noload_ff};
      ADDR_LAST_ACCESS_ADDRESS:       nxt_rdata = {16'h0000, last_addr_ff};
      ADDR_LAST_WORD_DATA:            nxt_rdata = {16'h0000, last_data_ff};
      ADDR_GENERAL_CONFIG_THREE:      nxt_rdata = {24'h000000, cfg3_ff};
      ADDR_LAST_OPERATION_TYPE:       nxt_rdata = {24'h000000, last_operation_type_ff};
      ADDR_ACTIVE_PATH_THRESHOLD:     nxt_rdata = {24'h000000, act_thr_ff};
      ADDR_REACTIVE_PATH_THRESHOLD:   nxt_rdata = {24'h000000, react_thr_ff};
      ADDR_APPARENT_PATH_THRESHOLD:   nxt_rdata = {24'h000000, app_thr_ff};
      ADDR_FIRST_HARMONIC_SELECTOR:   nxt_rdata = {24'h000000, sel_first_ff};
      ADDR_SECOND_HARMONIC_SELECTOR:  nxt_rdata = {24'h000000, sel_second_ff};
      default: begin
        nxt_rdata = 32'h0000_0000;
        hit       = 1'b0;
      end
    endcase
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      reg_rdata <= nxt_rdata;
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

  // ----------------------------------------
  // Writable configuration
  // ----------------------------------------

  // Only the listed writable offsets take data; read-only ones drop it
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      hcfg_ff         <= RST_HARMONIC_CALC_CONFIG;
      act_noload_ff   <= RST_NOLOAD_THRESHOLD;
      react_noload_ff <= RST_NOLOAD_THRESHOLD;
      app_noload_ff   <= RST_NOLOAD_THRESHOLD;
      cfg3_ff         <= RST_GENERAL_CONFIG_THREE;
      act_thr_ff      <= RST_PATH_THRESHOLD;
      react_thr_ff    <= RST_PATH_THRESHOLD;
      app_thr_ff      <= RST_PATH_THRESHOLD;
      sel_first_ff    <= RST_FIRST_HARMONIC_SEL;
      sel_second_ff   <= RST_SECOND_HARMONIC_SEL;
    end else if (reg_wr) begin
      // No check on all-ones thresholds: keeping that value out is the host's job
      case (reg_addr)
        ADDR_HARMONIC_CALC_CONFIG:      hcfg_ff         <= reg_wdata[15:0];
        ADDR_ACTIVE_NOLOAD_THRESHOLD:   act_noload_ff   <= reg_wdata[15:0];
        ADDR_REACTIVE_NOLOAD_THRESHOLD: react_noload_ff <= reg_wdata[15:0];
        ADDR_APPARENT_NOLOAD_THRESHOLD: app_noload_ff   <= reg_wdata[15:0];
        ADDR_GENERAL_CONFIG_THREE:      cfg3_ff         <= reg_wdata[7:0];
        ADDR_ACTIVE_PATH_THRESHOLD:     act_thr_ff      <= reg_wdata[7:0];
        ADDR_REACTIVE_PATH_THRESHOLD:   react_thr_ff    <= reg_wdata[7:0];
        ADDR_APPARENT_PATH_THRESHOLD:   app_thr_ff      <= reg_wdata[7:0];
        ADDR_FIRST_HARMONIC_SELECTOR:   sel_first_ff    <= reg_wdata[7:0];
        ADDR_SECOND_HARMONIC_SELECTOR:  sel_second_ff   <= reg_wdata[7:0];
        default: begin
          hcfg_ff <= hcfg_ff;
        end
      endcase
    end
  end

  // Configuration out is a registered copy of the flip-flops, one cycle behind, cleared to zero in reset
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      config_out <= '0;
    end else begin
      config_out <= '{harmonic_calc_config: hcfg_ff,
                      active_noload:        act_noload_ff,
                      reactive_noload:      react_noload_ff,
                      apparent_noload:      app_noload_ff,
                      general_config_three: cfg3_ff,
                      active_path_thr:      act_thr_ff,
                      reactive_path_thr:    react_thr_ff,
                      apparent_path_thr:    app_thr_ff,
                      first_harmonic_sel:   sel_first_ff,
                      second_harmonic_sel:  sel_second_ff};
    end
  end

  // ----------------------------------------
  // Access diagnostics
  // ----------------------------------------

  // A successful access is one to a mapped register; reserved holes do not count
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      last_addr_ff <= 16'h0000;
      last_operation_type_ff   <= OP_CODE_NONE;
    end else if ((reg_wr || reg_rd) && hit) begin
      last_addr_ff <= reg_addr;
      last_operation_type_ff   <= reg_wr ? OP_CODE_WRITE : OP_CODE_READ;
    end
  end

  // Data word of the last 16-bit access; a read of the capture itself shows the old word
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      last_data_ff <= 16'h0000;
    end else if (hit && width_class(reg_addr) == 2'h1) begin
      if (reg_wr) begin
        last_data_ff <= reg_wdata[15:0];
      end else if (reg_rd) begin
        last_data_ff <= nxt_rdata[15:0];
      end
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------

  property p_unmapped_zero;
    @(posedge sys_clk) disable iff (reset)
      (reg_rd && !hit) |=> (reg_rdata == 32'h0000_0000);
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read not zero");

  property p_last_addr;
    @(posedge sys_clk) disable iff (reset)
      ((reg_rd || reg_wr) && hit) |=> (last_addr_ff == $past(reg_addr));
  endproperty
  a_last_addr: assert property (p_last_addr) else $error("last address not recorded");

  property p_last_data_wr;
    @(posedge sys_clk) disable iff (reset)
      (reg_wr && hit && width_class(reg_addr) == 2'h1) |=> (last_data_ff == $past(reg_wdata[15:0]));
  endproperty
  a_last_data_wr: assert property (p_last_data_wr) else $error("16-bit write data not captured");

  property p_last_operation_type;
    @(posedge sys_clk) disable iff (reset)
      ((reg_rd || reg_wr) && hit) |=> (last_operation_type_ff == ($past(reg_wr) ? OP_CODE_WRITE : OP_CODE_READ));
  endproperty
  a_last_operation_type: assert property (p_last_operation_type) else $error("operation type wrong");

  property p_sign_ext;
    @(posedge sys_clk) disable iff (reset)
      (reg_rd && width_class(reg_addr) == 2'h2) |=> (reg_rdata[31:24] == {8{reg_rdata[23]}});
  endproperty
  a_sign_ext: assert property (p_sign_ext) else $error("24-bit result not sign extended");

  property p_noload_write;
    @(posedge sys_clk) disable iff (reset)
      (reg_wr && reg_addr == ADDR_APPARENT_NOLOAD_THRESHOLD) |=> ##1 (config_out.apparent_noload == $past(reg_wdata[15:0], 2));
  endproperty
  a_noload_write: assert property (p_noload_write) else $error("apparent no-load not written");

  property p_ro_write;
    @(posedge sys_clk) disable iff (reset)
      (reg_wr && reg_addr == ADDR_LAST_OPERATION_TYPE) |=> (last_operation_type_ff == OP_CODE_WRITE && last_addr_ff == ADDR_LAST_OPERATION_TYPE);
  endproperty
  a_ro_write: assert property (p_ro_write) else $error("read-only write mishandled");

  property p_period_read;
    @(posedge sys_clk) disable iff (reset)
      (reg_rd && reg_addr == ADDR_PHASE_B_LINE_PERIOD) |=> (reg_rdata == {16'h0000, $past(phase_in.period_b)});
  endproperty
  a_period_read: assert property (p_period_read) else $error("line period read wrong");

  property p_sel_write;
    @(posedge sys_clk) disable iff (reset)
      (reg_wr && reg_addr == ADDR_SECOND_HARMONIC_SELECTOR) ##1 (!reg_wr) ##1 reg_rd && reg_addr == ADDR_SECOND_HARMONIC_SELECTOR
        |=> (reg_rdata[7:0] == $past(reg_wdata[7:0], 3));
  endproperty
  a_sel_write: assert property (p_sel_write) else $error("selector readback wrong");

endmodule

`default_nettype wire

// ===== harm_host_model.sv
`timescale 1ns/100ps
`default_nettype none

module harm_host_model
  import harm_regs_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic [31:0] reg_rdata,
  output var  logic [15:0] reg_addr,
  output var  logic [31:0] reg_wdata,
  output var  logic        reg_wr,
  output var  logic        reg_rd
);
  // ----------------------------------------
  // Idle bus
  // ----------------------------------------
  initial begin
    reg_addr  = '0;
    reg_wdata = '0;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
  end

  // One-cycle write; address and data scrambled after so stale values never help
  task automatic write_reg(input logic [15:0] a, input logic [31:0] d);
    // Host firmware never programs all-ones into a no-load threshold
    if ((a == ADDR_ACTIVE_NOLOAD_THRESHOLD || a == ADDR_REACTIVE_NOLOAD_THRESHOLD ||
         a == ADDR_APPARENT_NOLOAD_THRESHOLD) && d[15:0] == NOLOAD_FORBIDDEN_VAL) begin
      return;
    end
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr    <= 1'b0;
    reg_addr  <= ~a;
    reg_wdata <= ~d;
  endtask

  // One-cycle read; data taken in the single cycle it stands
  task automatic read_reg(input logic [15:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd   <= 1'b0;
    reg_addr <= ~a;
    #1;
    d = reg_rdata;
  endtask
endmodule

`default_nettype wire

// ===== tb_harm_result_regs.sv
`timescale 1ns/100ps
`default_nettype none

module tb_harm_result_regs
  import harm_regs_pkg::*;
;
  logic            sys_clk = 1'b0;
  logic            reset   = 1'b1;
  logic [15:0]     reg_addr;
  logic [31:0]     reg_wdata;
  logic            reg_wr;
  logic            reg_rd;
  logic [31:0]     reg_rdata;
  harm_z_results_t z_in;
  phase_results_t  p_in;
  harm_config_t    config_out;
  harm_config_t    cfg_rst;
  int              n_mismatch = 0;
  int              cmp_count  = 0;
  logic [23:0]     zv [8] = '{24'h800001, 24'h7fffff, 24'hf00010, 24'h012345,
                              24'hfedcba, 24'h800000, 24'h000001, 24'hffffff};
  logic [23:0]     yv [2] = '{24'h9abcde, 24'h000fff};
  logic [15:0]     pv [6] = '{16'h8001, 16'h7fff, 16'hffff, 16'h4e20, 16'hc350, 16'h0001};
  logic [15:0]     rw_a [10] = '{ADDR_HARMONIC_CALC_CONFIG, ADDR_ACTIVE_NOLOAD_THRESHOLD,
                                 ADDR_REACTIVE_NOLOAD_THRESHOLD, ADDR_APPARENT_NOLOAD_THRESHOLD,
                                 ADDR_GENERAL_CONFIG_THREE, ADDR_ACTIVE_PATH_THRESHOLD,
                                 ADDR_REACTIVE_PATH_THRESHOLD, ADDR_APPARENT_PATH_THRESHOLD,
                                 ADDR_FIRST_HARMONIC_SELECTOR, ADDR_SECOND_HARMONIC_SELECTOR};
  logic [15:0]     rsv_a [7] = '{16'he8a0, 16'he8ff, 16'he901, 16'he90b, 16'he9fd, 16'hea05, 16'hea07};

  // ----------------------------------------
  // Clock, source values and instances
  // ----------------------------------------
  always #4 sys_clk = ~sys_clk;
  initial begin
    z_in = {zv[0], zv[1], zv[2], zv[3], zv[4], zv[5], zv[6], zv[7]};
    p_in = {yv[0], yv[1], pv[0], pv[1], pv[2], pv[3], pv[4], pv[5]};
  end
  assign cfg_rst = '{RST_HARMONIC_CALC_CONFIG, RST_NOLOAD_THRESHOLD, RST_NOLOAD_THRESHOLD,
                     RST_NOLOAD_THRESHOLD, RST_GENERAL_CONFIG_THREE, RST_PATH_THRESHOLD,
                     RST_PATH_THRESHOLD, RST_PATH_THRESHOLD, RST_FIRST_HARMONIC_SEL,
                     RST_SECOND_HARMONIC_SEL};

  harm_host_model u_harm_host_model (.sys_clk(sys_clk), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd));
  harm_result_regs u_harm_result_regs (.sys_clk(sys_clk), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .harm_z_in(z_in), .phase_in(p_in), .config_out(config_out));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] sx(input logic [23:0] v);
    return {{8{v[23]}}, v};
  endfunction

  // Write pattern: upper bits set so any leak past the register width shows
  function automatic logic [31:0] wv(input int i);
    return 32'hc0de_0000 + 32'h0000_1357 * 32'(i + 1);
  endfunction

  task automatic chk32(input logic [15:0] a, input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t addr %h got %h exp %h", $time, a, got, exp);
    end
  endtask

  task automatic chk_cfg(input harm_config_t got, input harm_config_t exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t config_out got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic rd_chk(input logic [15:0] a, input logic [31:0] exp);
    logic [31:0] d;
    u_harm_host_model.read_reg(a, d);
    chk32(a, d, exp);
  endtask

  task automatic print_verdict();
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Watchdog: a hang counts as a failure
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_mismatch++;
    print_verdict();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    logic [31:0] exp;
    repeat (10) @(posedge sys_clk);
    reset <= 1'b0;
    @(posedge sys_clk);
    #1;
    chk_cfg(config_out, cfg_rst);
    for (int i = 0; i < 10; i++) begin
      exp = (i < 4) ? {16'h0, cfg_rst[111 - 16*i -: 16]} : {24'h0, cfg_rst[47 - 8*(i-4) -: 8]};
      rd_chk(rw_a[i], exp);
    end
    // Write then read back every writable register, masked to its width
    for (int i = 0; i < 10; i++) u_harm_host_model.write_reg(rw_a[i], wv(i));
    for (int i = 0; i < 10; i++) begin
      exp = (i < 4) ? {16'h0, 16'(wv(i))} : {24'h0, 8'(wv(i))};
      rd_chk(rw_a[i], exp);
    end
    chk_cfg(config_out, '{16'(wv(0)), 16'(wv(1)), 16'(wv(2)), 16'(wv(3)), 8'(wv(4)),
      8'(wv(5)), 8'(wv(6)), 8'(wv(7)), 8'(wv(8)), 8'(wv(9))});
    // Signed 24-bit results sign extended, negative and positive; 16-bit results zero extended
    for (int i = 0; i < 8; i++) rd_chk(ADDR_HARM_Z_VOLT_RMS + 16'(i), sx(zv[i]));
    for (int i = 0; i < 2; i++) rd_chk(ADDR_HARM_Y_VOLT_DISTORTION + 16'(i), sx(yv[i]));
    for (int i = 0; i < 6; i++) rd_chk(ADDR_PHASE_A_POWER_FACTOR + 16'(i), {16'h0, pv[i]});
    // Read-only targets ignore writes
    u_harm_host_model.write_reg(ADDR_HARM_Z_ACTIVE_POWER, 32'h0);
    u_harm_host_model.write_reg(ADDR_PHASE_B_LINE_PERIOD, 32'h0);
    u_harm_host_model.write_reg(ADDR_LAST_OPERATION_TYPE, 32'h0);
    // Read the operation type first, before any other read overwrites it
    rd_chk(ADDR_LAST_OPERATION_TYPE, {24'h0, OP_CODE_WRITE});
    rd_chk(ADDR_HARM_Z_ACTIVE_POWER, sx(zv[2]));
    rd_chk(ADDR_PHASE_B_LINE_PERIOD, {16'h0, pv[4]});
    // Diagnostics after a 16-bit write, then reads
    u_harm_host_model.write_reg(ADDR_ACTIVE_NOLOAD_THRESHOLD, 32'hfa5e_2468);
    rd_chk(ADDR_LAST_WORD_DATA, 32'h0000_2468);
    rd_chk(ADDR_LAST_OPERATION_TYPE, {24'h0, OP_CODE_READ});
    rd_chk(ADDR_LAST_ACCESS_ADDRESS, {16'h0, ADDR_LAST_OPERATION_TYPE});
    rd_chk(ADDR_LAST_WORD_DATA, {16'h0, ADDR_LAST_OPERATION_TYPE});
    // Reserved holes read zero, even after a write, and leave diagnostics alone
    rd_chk(ADDR_APPARENT_PATH_THRESHOLD, {24'h0, wv(7)[7:0]});
    for (int i = 0; i < 7; i++) begin
      u_harm_host_model.write_reg(rsv_a[i], 32'hffff_ffff);
      rd_chk(rsv_a[i], 32'h0);
    end
    rd_chk(ADDR_LAST_ACCESS_ADDRESS, {16'h0, ADDR_APPARENT_PATH_THRESHOLD});
    // Reset in mid-run brings writable registers back
    @(posedge sys_clk);
    reset <= 1'b1;
    repeat (3) @(posedge sys_clk);
    reset <= 1'b0;
    @(posedge sys_clk);
    #1;
    chk_cfg(config_out, cfg_rst);
    rd_chk(ADDR_APPARENT_NOLOAD_THRESHOLD, 32'h0);
    print_verdict();
  end
endmodule

`default_nettype wire
